/* File: src/ssw_dev.sv */
// Purpose: serial command/status logic of the six-channel switch
// Assumes: all pins asynchronous to i_ref_clk, serial clock slow
// Notes: gates are active-high drive requests to the output stages
`timescale 1ns/1ps
`default_nettype none
module ssw_dev (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    ssw_if.dev spi,
    input wire logic i_mode_override,
    input wire logic [5:0] i_par_in,
    input wire logic i_pair_override_ch01,
    input wire logic i_pair_override_ch23,
    input wire logic i_pair_override_ch45,
    input wire logic [1:0] i_par_low_power,
    input wire logic [7:0] i_fault,
    input wire logic i_battery_supply_ov,
    output logic [5:0] o_gate,
    output logic o_low_power_channel_6,
    output logic o_low_power_channel_7,
    output logic o_on_open_load_enable_lo,
    output logic o_on_open_load_enable_hi
);

    // ********************************************
    // pin synchronisation
    // ********************************************
    logic [ssw_pkg::SYNC_W-1:0] raw_in;
    logic [ssw_pkg::SYNC_W-1:0] syn;
    logic sclk_s;
    logic cs_n_s;
    logic si_s;
    logic mode_s;
    logic [5:0] par_s;
    logic [2:0] pair_s;
    logic [1:0] lp_s;
    logic [7:0] fault_s;
    logic ov_s;

    assign raw_in = {spi.sclk, spi.cs_n, spi.si, i_mode_override, i_par_in,
                     i_pair_override_ch45, i_pair_override_ch23,
                     i_pair_override_ch01, i_par_low_power, i_fault,
                     i_battery_supply_ov};

    ssw_sync #(
        .W(ssw_pkg::SYNC_W)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_d(raw_in),
        .o_q(syn)
    );

    assign sclk_s = syn[23];
    assign cs_n_s = syn[22];
    assign si_s = syn[21];
    assign mode_s = syn[20];
    assign par_s = syn[19:14];
    assign pair_s = syn[13:11];
    assign lp_s = syn[10:9];
    assign fault_s = syn[8:1];
    assign ov_s = syn[0];

    // ********************************************
    // edge detection
    // ********************************************
    logic sclk_d_reg;
    logic cs_n_d_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic sel;

    // chip select idles high after reset so no false frame edge
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sclk_d_reg <= 1'b0;
            cs_n_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            cs_n_d_reg <= cs_n_s;
        end
    end

    // synchroniser output is 0 for two cycles after reset; mask it
    logic [1:0] warm_reg;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            warm_reg <= 2'h0;
        end else if (warm_reg != 2'h3) begin
            warm_reg <= warm_reg + 2'h1;
        end
    end

    assign sel = ~cs_n_s & (warm_reg == 2'h3);
    assign sclk_rise = sclk_s & ~sclk_d_reg & sel;
    assign sclk_fall = ~sclk_s & sclk_d_reg & sel;
    assign cs_fall = ~cs_n_s & cs_n_d_reg & (warm_reg == 2'h3);
    assign cs_rise = cs_n_s & ~cs_n_d_reg & (warm_reg == 2'h3);

    // ********************************************
    // receive shift register
    // ********************************************
    logic [7:0] rx_reg;

    // shifting goes on regardless of mode
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_reg <= 8'h00;
        end else if (sclk_rise) begin
            rx_reg <= {rx_reg[6:0], si_s};
        end
    end

    // ********************************************
    // fault register
    // ********************************************
    logic [7:0] fault_reg;
    logic [7:0] pend_reg;

    // frozen during frame, cleared after read
    // faults seen mid-frame wait in pend so none is lost
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            fault_reg <= ssw_pkg::FAULT_RESET;
            pend_reg <= 8'h00;
        end else if (cs_rise) begin
            fault_reg <= fault_s | pend_reg;
            pend_reg <= 8'h00;
        end else if (sel) begin
            pend_reg <= pend_reg | fault_s;
        end else begin
            fault_reg <= fault_reg | fault_s;
        end
    end

    // ********************************************
    // transmit shift register
    // ********************************************
    logic [7:0] tx_reg;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_reg <= 8'h00;
        end else if (cs_fall) begin
            tx_reg <= fault_reg;
        end else if (sclk_fall) begin
            tx_reg <= {tx_reg[6:0], rx_reg[0]};
        end
    end

    logic so_oe_n_reg;

    // drive only selected and mode low
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            so_oe_n_reg <= 1'b1;
        end else begin
            so_oe_n_reg <= ~(sel & ~mode_s);
        end
    end

    assign spi.so_o = tx_reg[7];
    assign spi.so_oe_n = so_oe_n_reg;

    // ********************************************
    // command latch
    // ********************************************
    logic [7:0] cmd_reg;

    // last byte loaded at frame end
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cmd_reg <= ssw_pkg::CMD_RESET;
        end else if (cs_rise) begin
            cmd_reg <= rx_reg;
        end
    end

    // ********************************************
    // channel control
    // ********************************************
    logic [5:0] pair_gate;
    logic [5:0] gate_next;

    // each pair input drives two channels
    assign pair_gate = {pair_s[2], pair_s[2], pair_s[1], pair_s[1],
                        pair_s[0], pair_s[0]};

    always_comb begin
        if (ov_s) begin
            gate_next = 6'h00;
        end else if (mode_s) begin
            gate_next = pair_gate;
        end else begin
            gate_next = cmd_reg[ssw_pkg::HP_CH-1:0] | par_s;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_gate <= 6'h00;
            o_low_power_channel_6 <= 1'b0;
            o_low_power_channel_7 <= 1'b0;
        end else begin
            o_gate <= gate_next;
            o_low_power_channel_6 <= lp_s[0] & ~mode_s;
            o_low_power_channel_7 <= lp_s[1] & ~mode_s;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_on_open_load_enable_lo <= 1'b0;
            o_on_open_load_enable_hi <= 1'b0;
        end else begin
            o_on_open_load_enable_lo <= cmd_reg[ssw_pkg::OL_LO_BIT];
            o_on_open_load_enable_hi <= cmd_reg[ssw_pkg::OL_HI_BIT];
        end
    end

endmodule
`default_nettype wire

/* File: src/ssw_host.sv */
// Purpose: controller end that frames 8/16-bit transfers
// Assumes: software drives the plain register port
// Notes: serial clock derived from i_ref_clk by a divider
`timescale 1ns/1ps
`default_nettype none
module ssw_host #(
    parameter int HALF_CYC = ssw_pkg::HOST_HALF_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    ssw_if.host spi,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata
);

    initial begin
        if (HALF_CYC < ssw_pkg::HOST_HALF_MIN || HALF_CYC > 255) begin
            $error("ssw_host: HALF_CYC out of range");
        end
    end

    // ********************************************
    // link sampling and state
    // ********************************************
    logic so_s;
    ssw_pkg::ssw_host_state_t state_reg;
    logic [7:0] cnt_reg;
    logic [4:0] bits_left_reg;
    logic half_done;
    logic phase_end;
    logic go;
    logic rise_ev;
    logic fall_ev;
    logic end_ev;
    logic busy;
    logic start_acc;
    logic start_pend_reg;
    logic len16_reg;
    logic done_reg;
    logic sclk_reg;
    logic cs_n_reg;
    logic [15:0] txd_reg;
    logic [15:0] tx_shift_reg;
    logic [15:0] rx_shift_reg;
    logic [15:0] rxd_reg;
    logic [31:0] rdata_next;

    // returned bit is a pin: two flops before use
    ssw_sync #(
        .W(1)
    ) u_so_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_d(spi.so),
        .o_q(so_s)
    );

    // divider pulse and the phase events it marks
    assign half_done = (cnt_reg == 8'h00);
    assign phase_end = half_done & (state_reg != ssw_pkg::HS_IDLE);
    assign go = (state_reg == ssw_pkg::HS_IDLE) & start_pend_reg;
    assign rise_ev = (state_reg == ssw_pkg::HS_LOW) & half_done;
    assign fall_ev = (state_reg == ssw_pkg::HS_HIGH) & half_done;
    assign end_ev = (state_reg == ssw_pkg::HS_LAG) & half_done;
    // gap counts as idle so a start may queue behind it
    assign busy = start_pend_reg | ((state_reg != ssw_pkg::HS_IDLE) &
                                    (state_reg != ssw_pkg::HS_GAP));
    assign start_acc = i_wr & (i_addr == ssw_pkg::REG_CTRL) &
                       i_wdata[ssw_pkg::CTRL_START] & ~busy;

    // ********************************************
    // frame sequencing
    // ********************************************
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ssw_pkg::HS_IDLE;
        end else begin
            case (state_reg)
                ssw_pkg::HS_IDLE: begin
                    if (go) begin
                        state_reg <= ssw_pkg::HS_LOW;
                    end
                end
                ssw_pkg::HS_LOW: begin
                    if (half_done) begin
                        state_reg <= ssw_pkg::HS_HIGH;
                    end
                end
                ssw_pkg::HS_HIGH: begin
                    if (half_done && bits_left_reg == 5'h00) begin
                        state_reg <= ssw_pkg::HS_LAG;
                    end else if (half_done) begin
                        state_reg <= ssw_pkg::HS_LOW;
                    end
                end
                ssw_pkg::HS_LAG: begin
                    if (half_done) begin
                        state_reg <= ssw_pkg::HS_GAP;
                    end
                end
                ssw_pkg::HS_GAP: begin
                    if (half_done) begin
                        state_reg <= ssw_pkg::HS_IDLE;
                    end
                end
                default: begin
                    state_reg <= ssw_pkg::HS_IDLE;
                end
            endcase
        end
    end

    // half-period divider, reloaded at every phase change
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= 8'h00;
        end else if (go || phase_end) begin
            cnt_reg <= 8'(HALF_CYC - 1);
        end else if (!half_done) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            bits_left_reg <= 5'h00;
        end else if (go && len16_reg) begin
            bits_left_reg <= ssw_pkg::BITS_16;
        end else if (go) begin
            bits_left_reg <= ssw_pkg::BITS_8;
        end else if (rise_ev) begin
            bits_left_reg <= bits_left_reg - 5'h01;
        end
    end

    // ********************************************
    // link pins
    // ********************************************
    // clock idles low
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sclk_reg <= 1'b0;
            cs_n_reg <= 1'b1;
        end else begin
            if (go) begin
                cs_n_reg <= 1'b0;
            end else if (end_ev) begin
                cs_n_reg <= 1'b1;
            end
            if (rise_ev) begin
                sclk_reg <= 1'b1;
            end else if (fall_ev) begin
                sclk_reg <= 1'b0;
            end
        end
    end

    // data set a half period before rise
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_shift_reg <= 16'h0000;
        end else if (go && len16_reg) begin
            tx_shift_reg <= txd_reg;
        end else if (go) begin
            tx_shift_reg <= {txd_reg[7:0], 8'h00};
        end else if (fall_ev && bits_left_reg != 5'h00) begin
            tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
        end
    end

    // returned bit taken at the rise
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_shift_reg <= 16'h0000;
        end else if (go) begin
            rx_shift_reg <= 16'h0000;
        end else if (rise_ev) begin
            rx_shift_reg <= {rx_shift_reg[14:0], so_s};
        end
    end

    assign spi.sclk = sclk_reg;
    assign spi.cs_n = cs_n_reg;
    assign spi.si = tx_shift_reg[15];

    // ********************************************
    // register port
    // ********************************************
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            txd_reg <= 16'h0000;
            len16_reg <= 1'b0;
        end else begin
            if (i_wr && i_addr == ssw_pkg::REG_TXD) begin
                txd_reg <= i_wdata[15:0];
            end
            if (start_acc) begin
                len16_reg <= i_wdata[ssw_pkg::CTRL_LEN16];
            end
        end
    end

    // a start while busy is dropped, not queued
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            start_pend_reg <= 1'b0;
        end else if (go) begin
            start_pend_reg <= 1'b0;
        end else if (start_acc) begin
            start_pend_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            done_reg <= 1'b0;
            rxd_reg <= 16'h0000;
        end else if (end_ev) begin
            done_reg <= 1'b1;
            rxd_reg <= rx_shift_reg;
        end else if (start_acc) begin
            done_reg <= 1'b0;
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (i_addr)
            ssw_pkg::REG_CTRL: begin
                rdata_next[ssw_pkg::CTRL_LEN16] = len16_reg;
            end
            ssw_pkg::REG_TXD: begin
                rdata_next[15:0] = txd_reg;
            end
            ssw_pkg::REG_RXD: begin
                rdata_next[15:0] = rxd_reg;
            end
            ssw_pkg::REG_STAT: begin
                rdata_next[ssw_pkg::STAT_BUSY] = busy;
                rdata_next[ssw_pkg::STAT_DONE] = done_reg;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            o_rdata <= rdata_next;
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

/* File: src/ssw_if.sv */
// Purpose: serial link between controller and switch device
// Assumes: serial output has an external pull-up
// Notes: released output reads as all ones
`timescale 1ns/1ps
`default_nettype none
interface ssw_if;
    logic sclk;
    logic cs_n;
    logic si;
    logic so_o;
    logic so_oe_n;
    logic so;

    // pull-up: a released line reads high
    assign so = so_oe_n ? 1'b1 : so_o;

    modport dev (
        input sclk,
        input cs_n,
        input si,
        output so_o,
        output so_oe_n
    );

    modport host (
        output sclk,
        output cs_n,
        output si,
        input so
    );
endinterface
`default_nettype wire

/* File: src/ssw_pkg.sv */
// Purpose: shared constants for the six-channel switch serial link
// Assumes: one reference clock; both ends sample the link pins
// Notes: no register offsets on the device side; host has its own map
//
// What this block does
// - transfers are 8 or 16 bits, MSB first
// - command bits 5..0 switch channels 5..0
// - command bits 6,7 enable on-state open-load detect
// - mode low: channel on if serial OR parallel
// - mode high: serial bits 5..0 ignored, bits 6,7 still applied, shifting continues
// - mode high: pair inputs drive both paired channels
// - pair inputs ignored while mode low
// - mode high forces low-power channels 6,7 off
// - serial output driven only when selected, mode low
// - serial output changes on falling serial clock
// - status byte: channel 7 fault first
// - bit 1 means on or fault, 0 off or none
// - 16-bit transfer returns status then first command
// - master sets data valid at rising clock
// - serial clock low when chip select falls
// - one clock pulse per bit, idle between transfers
// - over-voltage forces all six gates off
// - chip select rise loads last command byte
// - chip select fall freezes faults; clear after read
// - power-up clears serial command register
package ssw_pkg;

    localparam int CMD_W = 8;
    localparam int HP_CH = 6;
    localparam int OL_LO_BIT = 6;
    localparam int OL_HI_BIT = 7;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] FAULT_RESET = 8'h00;
    localparam int SYNC_W = 24;

    // host divider: cycles per serial clock half period
    localparam int HOST_HALF_CYC = 8;
    localparam int HOST_HALF_MIN = 6;
    localparam logic [4:0] BITS_8 = 5'h08;
    localparam logic [4:0] BITS_16 = 5'h10;

    // host register map (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TXD = 4'h4;
    localparam logic [3:0] REG_RXD = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hC;
    localparam int CTRL_START = 0;
    localparam int CTRL_LEN16 = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;

    typedef enum logic [2:0] {
        HS_IDLE,
        HS_LOW,
        HS_HIGH,
        HS_LAG,
        HS_GAP
    } ssw_host_state_t;

endpackage

/* File: src/ssw_sync.sv */
// Purpose: two-flop synchroniser for a bundle of pins
// Assumes: bits are independent levels
// Notes: first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module ssw_sync #(
    parameter int W = 1
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_reg;

    initial begin
        if (W < 1) begin
            $error("ssw_sync: width must be at least 1");
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= '0;
            o_q <= '0;
        end else begin
            meta_reg <= i_d;
            o_q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* File: test/ssw_sva.sv */
// Purpose: wire-level checks on the serial link
// Assumes: host runs its default divider
// Notes: device pin delay stays below eight cycles
`timescale 1ns/1ps
`default_nettype none
module ssw_sva (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_so_oe_n,
    input wire logic i_so
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic [4:0] nbit_reg;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            nbit_reg <= 5'h00;
        end else if (i_cs_n) begin
            nbit_reg <= 5'h00;
        end else if ($rose(i_sclk)) begin
            nbit_reg <= nbit_reg + 5'h01;
        end
    end
    sequence frame_end_s;
        $rose(i_cs_n);
    endsequence
    sequence clk_rise_s;
        $rose(i_sclk);
    endsequence
    bit_count_a: assert property (frame_end_s |->
        nbit_reg == 5'h08 || nbit_reg == 5'h10) else $error("bad count");
    lead_low_a: assert property ($fell(i_cs_n) |-> !i_sclk)
        else $error("clock high at select");
    lag_low_a: assert property (frame_end_s |-> !i_sclk)
        else $error("clock high at deselect");
    idle_low_a: assert property (i_cs_n && $past(i_cs_n) |-> !i_sclk)
        else $error("clock moved while idle");
    high_width_a: assert property (clk_rise_s |=> i_sclk[*5])
        else $error("clock high too short");
    si_valid_a: assert property (i_sclk |-> $stable(i_si))
        else $error("data moved while clock high");
    so_steady_a: assert property (i_sclk && $past(i_sclk) |->
        $stable(i_so)) else $error("output moved while clock high");
    so_release_a: assert property (frame_end_s |-> ##[1:8] i_so_oe_n)
        else $error("output not released");
    idle_release_a: assert property (i_cs_n[*8] |-> i_so_oe_n)
        else $error("output driven while idle");
endmodule
`default_nettype wire

/* File: test/test_six_channel_switch_spi_control.sv */
// Purpose: host and device joined, user sides driven
// Assumes: rx holds status above echo in 16-bit frames
// Notes: output checks poll, pin paths are synchronised
`timescale 1ns/1ps
`default_nettype none
module test_six_channel_switch_spi_control;
    logic i_ref_clk, i_rst, i_wr, i_rd, i_mode_override;
    logic i_pair_override_ch01, i_pair_override_ch23;
    logic i_pair_override_ch45, i_battery_supply_ov;
    logic [3:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [5:0] i_par_in, o_gate;
    logic [1:0] i_par_low_power;
    logic [7:0] i_fault;
    logic o_low_power_channel_6, o_low_power_channel_7;
    logic o_on_open_load_enable_lo, o_on_open_load_enable_hi;
    logic [9:0] obs;
    int miscompares = 0;
    int n_tests = 0;
    assign obs = {o_low_power_channel_7, o_low_power_channel_6,
        o_on_open_load_enable_hi, o_on_open_load_enable_lo, o_gate};
    ssw_if ifc ();
    ssw_dev i_ssw_dev (.i_ref_clk, .i_rst, .spi(ifc.dev), .i_mode_override,
        .i_par_in, .i_pair_override_ch01, .i_pair_override_ch23,
        .i_pair_override_ch45, .i_par_low_power, .i_fault,
        .i_battery_supply_ov, .o_gate, .o_low_power_channel_6,
        .o_low_power_channel_7, .o_on_open_load_enable_lo,
        .o_on_open_load_enable_hi);
    ssw_host i_ssw_host (.i_ref_clk, .i_rst, .spi(ifc.host), .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata);
    ssw_sva i_ssw_sva (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_sclk(ifc.sclk), .i_cs_n(ifc.cs_n), .i_si(ifc.si),
        .i_so_oe_n(ifc.so_oe_n), .i_so(ifc.so));
    // ***************************
    // shared tasks
    // ***************************
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_ref_clk);
    endtask
    task automatic xfer(input logic l16, input logic [15:0] tx,
            input logic [15:0] exp);
        logic [31:0] d;
        int n;
        wr(ssw_pkg::REG_TXD, {16'h0000, tx});
        wr(ssw_pkg::REG_CTRL, {30'h0, l16, 1'b1});
        for (n = 0; n < 100 && ifc.cs_n !== 1'b0; n++) @(posedge i_ref_clk);
        for (n = 0; n < 900 && ifc.cs_n !== 1'b1; n++) @(posedge i_ref_clk);
        repeat (4) @(posedge i_ref_clk);
        if (ifc.cs_n !== 1'b1) begin
            miscompares++;
            complete_run();
        end
        rd(ssw_pkg::REG_STAT, d);
        chk("done", 16'h0002, {14'h0, d[ssw_pkg::STAT_DONE],
            d[ssw_pkg::STAT_BUSY]});
        rd(ssw_pkg::REG_RXD, d);
        chk("rx", exp, l16 ? d[15:0] : {8'h00, d[7:0]});
    endtask
    task automatic expect_out(input logic [9:0] exp);
        for (int n = 0; n < 40 && obs !== exp; n++) @(posedge i_ref_clk);
        chk("outputs", {6'h00, exp}, {6'h00, obs});
    endtask
    // ***************************
    // scenarios
    // ***************************
    task automatic t_power_up();
        expect_out(10'h000);
        xfer(1'b0, 16'h0000, 16'h0000);
    endtask
    task automatic t_serial();
        xfer(1'b0, 16'h003F, 16'h0000);
        expect_out(10'h03F);
        xfer(1'b0, 16'h00C5, 16'h0000);
        expect_out(10'h0C5);
        i_par_in <= 6'h0A;
        xfer(1'b0, 16'h0005, 16'h0000);
        expect_out(10'h00F);
        i_par_in <= 6'h00;
    endtask
    task automatic t_fault();
        i_fault <= 8'h81;
        repeat (8) @(posedge i_ref_clk);
        xfer(1'b0, 16'h0000, 16'h0081);
        i_fault <= 8'h00;
        xfer(1'b0, 16'h0000, 16'h0081);
        xfer(1'b0, 16'h0000, 16'h0000);
    endtask
    task automatic t_echo();
        i_fault <= 8'h02;
        repeat (8) @(posedge i_ref_clk);
        xfer(1'b1, 16'hA513, 16'h02A5);
        expect_out(10'h013);
        i_fault <= 8'h00;
    endtask
    task automatic t_mode();
        i_mode_override <= 1'b1;
        i_par_in <= 6'h3F;
        i_pair_override_ch01 <= 1'b1;
        i_pair_override_ch45 <= 1'b1;
        i_par_low_power <= 2'b11;
        xfer(1'b0, 16'h000C, 16'h00FF);
        expect_out(10'h033);
        i_mode_override <= 1'b0;
        i_par_in <= 6'h00;
        expect_out(10'h30C);
        i_battery_supply_ov <= 1'b1;
        expect_out(10'h300);
        i_battery_supply_ov <= 1'b0;
        expect_out(10'h30C);
    endtask
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        {i_wr, i_rd, i_mode_override, i_battery_supply_ov} = 4'h0;
        {i_pair_override_ch01, i_pair_override_ch23} = 2'b00;
        i_pair_override_ch45 = 1'b0;
        {i_addr, i_wdata, i_par_in, i_par_low_power, i_fault} = '0;
        i_rst = 1'b1;
        repeat (5) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        t_power_up();
        t_serial();
        t_fault();
        t_echo();
        t_mode();
        complete_run();
    end
endmodule
`default_nettype wire
